// *** rtl/eeprom_slave_pkg.sv ***
// Constants, states and state carriers of the serial EEPROM slave front end
package eeprom_slave_pkg;

   // ------------------------------------------------------------------
   // Array geometry
   // ------------------------------------------------------------------
   localparam int ADDR_W      = 11;                 // 2048 bytes
   localparam int MEM_BYTES   = 1 << ADDR_W;
   localparam int PAGE_BYTES  = 16;
   localparam int PAGE_LSB    = 4;                  // address bits below the page number
   localparam int PAGES       = MEM_BYTES / PAGE_BYTES;
   localparam int PAGE_W      = ADDR_W - PAGE_LSB;
   localparam int HI_W        = ADDR_W - 8;         // upper address bits in the command byte

   // ------------------------------------------------------------------
   // Command byte layout
   // ------------------------------------------------------------------
   localparam int          CMD_RW_BIT   = 0;        // 0 write select, 1 read select
   localparam int          CMD_HI_LSB   = 1;
   localparam int          CMD_TYPE_LSB = 4;
   localparam logic [3:0]  DEV_TYPE     = 4'h5;     // Arbitrary type code
   localparam logic [3:0]  BITS_DATA    = 4'h8;     // Data bits before the acknowledge

   // ------------------------------------------------------------------
   // Timing at 200 MHz
   // ------------------------------------------------------------------
   localparam int CLK_MHZ      = 200;
   localparam int PROG_TIME_US = 10000;             // 10 ms longest erase/write
   localparam int PROG_CYCLES  = PROG_TIME_US * CLK_MHZ;

   // ------------------------------------------------------------------
   // Transfer states
   // ------------------------------------------------------------------
   typedef enum logic [5:0] {
      ST_IDLE   = 6'h01,
      ST_CMD    = 6'h02,
      ST_ADDR   = 6'h04,
      ST_WDATA  = 6'h08,
      ST_RDATA  = 6'h10,
      ST_IGNORE = 6'h20
   } xfer_e;

   // ------------------------------------------------------------------
   // State carriers
   // ------------------------------------------------------------------
   typedef struct packed {
      logic        bit_v;     // last bit captured at the clock rise
      logic        tgl;       // toggles once per captured bit
   } link_s;

   typedef struct packed {
      xfer_e                         st;
      logic [3:0]                    cnt;
      logic [7:0]                    shreg;
      logic [7:0]                    tx;
      logic                          drive;     // 1 pulls the data line low
      logic                          rd;
      logic [HI_W-1:0]               hi;
      logic [ADDR_W-1:0]             addr;
      logic [PAGE_BYTES-1:0][7:0]    wbuf;
      logic [PAGE_BYTES-1:0]         mask;
      logic                          busy;
      logic [31:0]                   pcnt;
      logic [4:0]                    pidx;
      logic [PAGES-1:0]              prot;
      logic                          scl_m;
      logic                          scl_s;
      logic                          sda_m;
      logic                          sda_s;
      logic                          sda_p;
      logic                          wp_m;
      logic                          wp_s;
      logic                          tg_m;
      logic                          tg_s;
      logic                          tg_p;
   } sys_s;

endpackage

// *** rtl/eeprom_slave.sv ***
// Two-wire serial EEPROM slave front end with array, page protection and program timer

// Function
// - Sample on clock rise, drive on fall
// - Data line open drain only
// - Select inputs ignored
// - Write-protect pin blocks upper half writes
// - Byte array in pages, protection per page
// - Slave only, never drives clock
// - Standby after stop or programming
// - Start: data falls while clock high
// - Stop: data rises while clock high
// - Stop after write starts programming
// - Stop after read just returns standby
// - Receiver acknowledges by pulling low
// - Transmitter releases line for acknowledge
// - Device acknowledges each received byte of an addressed frame
// - Data changes only while clock low
// - Nine clocks per byte, MSB first
// - Command bit 0 selects write/read
// - Write command carries upper address bits
// - Byte after write command is address
// - Read continues while master acknowledges
// - Address counter advances per read byte
// - No acknowledge while programming runs
module eeprom_slave #(
   parameter int PROG_CYCLES = eeprom_slave_pkg::PROG_CYCLES
) (
   // System clock and reset
   input  wire logic                                CLK_SYS,
   input  wire logic                                RST_N,
   // Serial link, clock from the master
   input  wire logic                                SCL,
   input  wire logic                                SDA_I,
   output logic                                     SDA_O,
   output logic                                     SDA_OE,
   // Unused select pins
   input  wire logic                                UNUSED_SELECT_INPUT_0,
   input  wire logic                                UNUSED_SELECT_INPUT_1,
   input  wire logic                                UNUSED_SELECT_INPUT_2,
   // Protection controls
   input  wire logic                                WRITE_PROTECT,
   input  wire logic                                PROT_SET,
   input  wire logic [eeprom_slave_pkg::PAGE_W-1:0] PROT_PAGE,
   // Status
   output logic                                     STANDBY,
   output logic                                     PROG_BUSY
);

   // ------------------------------------------------------------------
   // Declarations
   // ------------------------------------------------------------------
   eeprom_slave_pkg::link_s                  lk_q;
   eeprom_slave_pkg::link_s                  lk_d;
   eeprom_slave_pkg::sys_s                   q;
   eeprom_slave_pkg::sys_s                   d;
   logic                                     oe_q;
   logic [7:0]                               mem [0:eeprom_slave_pkg::MEM_BYTES-1];
   logic                                     mem_we;
   logic [eeprom_slave_pkg::ADDR_W-1:0]      mem_waddr;
   logic [7:0]                               mem_wdata;
   logic [7:0]                               rd_byte;
   logic [7:0]                               rx_byte;
   logic                                     ev;
   logic                                     start_c;
   logic                                     stop_c;
   logic                                     active;
   logic                                     blocked;

   // ------------------------------------------------------------------
   // Link domain, clocked by the master's serial clock
   // ------------------------------------------------------------------

   // rise capture
   // One bit per rise; the toggle tells the system side a new bit stands
   always_comb begin
      lk_d       = lk_q;
      lk_d.bit_v = SDA_I;
      lk_d.tgl   = ~lk_q.tgl;
   end

   always_ff @(posedge SCL or negedge RST_N) begin
      if (!RST_N) begin
         lk_q <= '0;
      end else begin
         lk_q <= lk_d;
      end
   end

   // fall launch
   // The drive level is settled by the system side tens of ns after a rise
   // and held until the next rise, so the fall always sees a stable value
   always_ff @(negedge SCL or negedge RST_N) begin
      if (!RST_N) begin
         oe_q <= 1'b0;
      end else begin
         oe_q <= q.drive;
      end
   end

   // ------------------------------------------------------------------
   // Pin outputs
   // ------------------------------------------------------------------

   // open drain
   // Gating with the frame state releases the line at a stop, when no
   // further clock fall arrives to clear the link flop
   assign SDA_O  = 1'b0;
   assign active = (q.st != eeprom_slave_pkg::ST_IDLE)
                   && (q.st != eeprom_slave_pkg::ST_IGNORE);
   assign SDA_OE = oe_q & active;

   assign STANDBY   = (q.st == eeprom_slave_pkg::ST_IDLE) & ~q.busy;
   assign PROG_BUSY = q.busy;

   // select pins
   // Select inputs reach no logic: the device answers every address bit set

   // ------------------------------------------------------------------
   // System domain helpers
   // ------------------------------------------------------------------

   assign start_c = q.scl_s & q.sda_p & ~q.sda_s;
   assign stop_c  = q.scl_s & ~q.sda_p & q.sda_s;
   // Bit event from the link toggle, seen after two flops
   assign ev      = q.tg_s ^ q.tg_p;
   assign rx_byte = {q.shreg[6:0], lk_q.bit_v};
   assign rd_byte = mem[q.addr];

   assign blocked = q.prot[q.addr[eeprom_slave_pkg::ADDR_W-1:eeprom_slave_pkg::PAGE_LSB]]
                    | (q.wp_s & q.addr[eeprom_slave_pkg::ADDR_W-1]);

   // ------------------------------------------------------------------
   // System domain next state
   // ------------------------------------------------------------------
   always_comb begin
      d         = q;
      mem_we    = 1'b0;
      mem_waddr = '0;
      mem_wdata = '0;

      // Synchronisers for the pins and the link toggle
      d.scl_m = SCL;
      d.scl_s = q.scl_m;
      d.sda_m = SDA_I;
      d.sda_s = q.sda_m;
      d.sda_p = q.sda_s;
      d.wp_m  = WRITE_PROTECT;
      d.wp_s  = q.wp_m;
      d.tg_m  = lk_q.tgl;
      d.tg_s  = q.tg_m;
      d.tg_p  = q.tg_s;

      // Protection bits only ever get set here; clearing is not supported
      if (PROT_SET) begin
         d.prot[PROT_PAGE] = 1'b1;
      end

      // Programming: commit buffered bytes one per cycle, then wait out the time
      if (q.busy) begin
         if (q.pidx < 5'(eeprom_slave_pkg::PAGE_BYTES)) begin
            if (q.mask[q.pidx[3:0]] && !blocked) begin
               mem_we    = 1'b1;
               mem_waddr = {q.addr[eeprom_slave_pkg::ADDR_W-1:eeprom_slave_pkg::PAGE_LSB],
                            q.pidx[3:0]};
               mem_wdata = q.wbuf[q.pidx[3:0]];
            end
            d.pidx = q.pidx + 5'h1;
         end
         d.pcnt = q.pcnt + 32'h1;
         if (q.pcnt == 32'(PROG_CYCLES - 1)) begin
            d.busy = 1'b0;
            d.mask = '0;
         end
      end

      if (stop_c) begin
         if ((q.st == eeprom_slave_pkg::ST_WDATA) && (|q.mask) && !q.busy) begin
            d.busy = 1'b1;
            d.pcnt = '0;
            d.pidx = '0;
         end
         d.st    = eeprom_slave_pkg::ST_IDLE;
         d.cnt   = '0;
         d.drive = 1'b0;
      end else if (start_c) begin
         // command follows start
         // A repeated start abandons any write still being entered
         d.st    = eeprom_slave_pkg::ST_CMD;
         d.cnt   = '0;
         d.drive = 1'b0;
         if (!q.busy) begin
            d.mask = '0;
         end
      end else if (ev && (q.st != eeprom_slave_pkg::ST_IDLE)
                      && (q.st != eeprom_slave_pkg::ST_IGNORE)) begin
         if (q.cnt != eeprom_slave_pkg::BITS_DATA) begin
            // Data bit phase
            d.shreg = rx_byte;
            d.cnt   = q.cnt + 4'h1;
            if (q.st == eeprom_slave_pkg::ST_RDATA) begin
               if (q.cnt == eeprom_slave_pkg::BITS_DATA - 4'h1) begin
                  d.drive = 1'b0;
               end else begin
                  d.drive = ~q.tx[6];
                  d.tx    = {q.tx[6:0], 1'b0};
               end
            end else if (q.cnt == eeprom_slave_pkg::BITS_DATA - 4'h1) begin
               // Eighth bit in: decide the acknowledge for the coming slot
               case (q.st)
                  eeprom_slave_pkg::ST_CMD: begin
                     if ((rx_byte[7:eeprom_slave_pkg::CMD_TYPE_LSB] !=
                          eeprom_slave_pkg::DEV_TYPE) || q.busy) begin
                        d.st    = eeprom_slave_pkg::ST_IGNORE;
                        d.drive = 1'b0;
                     end else begin
                        d.drive = 1'b1;
                        d.rd    = rx_byte[eeprom_slave_pkg::CMD_RW_BIT];
                        if (!rx_byte[eeprom_slave_pkg::CMD_RW_BIT]) begin
                           d.hi = rx_byte[eeprom_slave_pkg::HI_W:eeprom_slave_pkg::CMD_HI_LSB];
                        end
                     end
                  end
                  eeprom_slave_pkg::ST_ADDR: begin
                     d.addr  = {q.hi, rx_byte};
                     d.drive = 1'b1;
                  end
                  eeprom_slave_pkg::ST_WDATA: begin
                     // Bytes wrap inside the page; only the low nibble counts
                     d.wbuf[q.addr[3:0]] = rx_byte;
                     d.mask[q.addr[3:0]] = 1'b1;
                     d.addr[3:0]         = q.addr[3:0] + 4'h1;
                     d.drive             = 1'b1;
                  end
                  default: begin
                     d.drive = 1'b0;
                  end
               endcase
            end
         end else begin
            // Acknowledge slot rise
            d.cnt   = '0;
            d.drive = 1'b0;
            case (q.st)
               eeprom_slave_pkg::ST_CMD: begin
                  if (q.rd) begin
                     d.st    = eeprom_slave_pkg::ST_RDATA;
                     d.tx    = rd_byte;
                     d.drive = ~rd_byte[7];
                     d.addr  = q.addr + 11'h1;
                  end else begin
                     d.st = eeprom_slave_pkg::ST_ADDR;
                  end
               end
               eeprom_slave_pkg::ST_ADDR: begin
                  d.st = eeprom_slave_pkg::ST_WDATA;
               end
               eeprom_slave_pkg::ST_RDATA: begin
                  if (!lk_q.bit_v) begin
                     d.tx    = rd_byte;
                     d.drive = ~rd_byte[7];
                     d.addr  = q.addr + 11'h1;
                  end else begin
                     d.st = eeprom_slave_pkg::ST_IGNORE;
                  end
               end
               default: begin
                  d.drive = 1'b0;
               end
            endcase
         end
      end
   end

   // ------------------------------------------------------------------
   // System domain registers
   // ------------------------------------------------------------------

   // slave only
   // Reset leaves the lines released and the block in standby
   always_ff @(posedge CLK_SYS or negedge RST_N) begin
      if (!RST_N) begin
         q       <= '0;
         q.st    <= eeprom_slave_pkg::ST_IDLE;
         q.scl_m <= 1'b1;
         q.scl_s <= 1'b1;
         q.sda_m <= 1'b1;
         q.sda_s <= 1'b1;
         q.sda_p <= 1'b1;
      end else begin
         q <= d;
      end
   end

   // Array write port; content is non-volatile so it has no reset
   always_ff @(posedge CLK_SYS) begin
      if (mem_we) begin
         mem[mem_waddr] <= mem_wdata;
      end
   end

endmodule // eeprom_slave

// *** tb/eeprom_slave_assertions.sv ***
// Port checks for the serial EEPROM slave front end
// ----------------------------------------
// Checker
// ----------------------------------------
module eeprom_slave_assertions #(
   parameter int PROG_CYCLES = eeprom_slave_pkg::PROG_CYCLES
) (
   // System side
   input wire logic CLK_SYS,
   input wire logic RST_N,
   // Serial link
   input wire logic SCL,
   input wire logic SDA_I,
   input wire logic SDA_O,
   input wire logic SDA_OE,
   // Status
   input wire logic STANDBY,
   input wire logic PROG_BUSY
);
   timeunit 1ns;
   timeprecision 100ps;
   logic [3:0] rises_q;
   logic [7:0] cmd_q;
   logic [3:0] stop_q;
   int         busy_q;
   logic       ign_q;

   default clocking cb @(posedge CLK_SYS); endclocking
   default disable iff (!RST_N);

   // Rises since start, command bits, stop age, busy length
   always_ff @(posedge CLK_SYS or negedge RST_N) begin
      if (!RST_N) begin
         rises_q <= 4'h0;
         cmd_q   <= 8'h00;
         stop_q  <= 4'hf;
         busy_q  <= 0;
         ign_q   <= 1'b0;
      end else begin
         if (SCL && $fell(SDA_I)) begin
            rises_q <= 4'h0;
            ign_q   <= 1'b0;
         end else if ($rose(SCL) && rises_q != 4'hf) begin
            rises_q <= rises_q + 4'h1;
         end
         if ($rose(SCL) && rises_q < 4'h8) begin
            cmd_q <= {cmd_q[6:0], SDA_I};
         end
         if (rises_q == 4'h8 && $fell(SCL) && cmd_q[7:4] != eeprom_slave_pkg::DEV_TYPE) begin
            ign_q <= 1'b1;
         end
         // Saturates, so a stale stop never looks fresh
         stop_q <= (SCL && $rose(SDA_I)) ? 4'h0 : ((stop_q == 4'hf) ? 4'hf : stop_q + 4'h1);
         busy_q <= PROG_BUSY ? busy_q + 1 : 0;
      end
   end

   sequence eighth_fall_s;
      rises_q == 4'h8 && $fell(SCL);
   endsequence
   property ack_p;
      eighth_fall_s ##0 (cmd_q[7:4] == eeprom_slave_pkg::DEV_TYPE && !PROG_BUSY)
         |-> ##[0:3] SDA_OE;
   endproperty

   open_drain_a : assert property (SDA_O == 1'b0)
      else $error("data line driven high");
   drive_low_a : assert property ($rose(SDA_OE) |-> !SCL)
      else $error("pull started while clock high");
   hold_high_a : assert property (SCL && $past(SCL) |-> $stable(SDA_OE))
      else $error("data moved while clock high");
   cmd_quiet_a : assert property (rises_q < 4'h8 |-> !SDA_OE)
      else $error("pull during command bits");
   ack_slot_a : assert property (ack_p)
      else $error("addressed command not acknowledged");
   ignore_quiet_a : assert property (ign_q |-> !SDA_OE)
      else $error("pull in ignored frame");
   busy_quiet_a : assert property (PROG_BUSY |-> !SDA_OE)
      else $error("pull while programming");
   prog_stop_a : assert property ($rose(PROG_BUSY) |-> stop_q < 4'hf)
      else $error("programming without stop");
   busy_len_a : assert property ($fell(PROG_BUSY) |->
      busy_q >= PROG_CYCLES - 1 && busy_q <= PROG_CYCLES + 1)
      else $error("programming length wrong");
   busy_idle_a : assert property (PROG_BUSY |-> !STANDBY)
      else $error("standby while programming");
endmodule // eeprom_slave_assertions

bind eeprom_slave eeprom_slave_assertions #(.PROG_CYCLES(PROG_CYCLES)) chk (
   .CLK_SYS(CLK_SYS), .RST_N(RST_N), .SCL(SCL), .SDA_I(SDA_I), .SDA_O(SDA_O),
   .SDA_OE(SDA_OE), .STANDBY(STANDBY), .PROG_BUSY(PROG_BUSY));

// *** tb/i2c_bus_master.sv ***
// Two-wire bus master model: makes the clock, pulls the data line
module i2c_bus_master #(
   parameter int Q = 3
) (
   // Model timebase
   input  wire logic lclk,
   // Bus
   input  wire logic sda,
   output logic      scl,
   output logic      sda_oe
);
   timeunit 1ns;
   timeprecision 100ps;
   // Bus idles released and high
   initial begin
      scl    = 1'b1;
      sda_oe = 1'b0;
   end

   task automatic tick(input int n);
      repeat (n) @(posedge lclk);
   endtask

   task automatic start_c();
      tick(1);
      sda_oe <= 1'b0;
      tick(Q);
      scl <= 1'b1;
      tick(Q);
      sda_oe <= 1'b1;
      tick(Q);
      scl <= 1'b0;
      tick(Q);
   endtask

   task automatic stop_c();
      tick(1);
      sda_oe <= 1'b1;
      tick(Q);
      scl <= 1'b1;
      tick(Q);
      sda_oe <= 1'b0;
      tick(2 * Q);
   endtask

   task automatic bit_io(input logic b, output logic r);
      sda_oe <= !b;
      tick(Q);
      scl <= 1'b1;
      tick(Q);
      r = sda;
      tick(Q);
      scl <= 1'b0;
      tick(Q);
   endtask

   task automatic byte_io(input logic [7:0] tx, input logic ack_in,
                          output logic [7:0] rx, output logic ack_out);
      logic r;
      for (int i = 7; i >= 0; i--) begin
         bit_io(tx[i], r);
         rx[i] = r;
      end
      bit_io(ack_in, ack_out);
   endtask
endmodule // i2c_bus_master

// *** tb/testbench.sv ***
// Self-checking bench for the serial EEPROM slave front end
module testbench;
   timeunit 1ns;
   timeprecision 100ps;

   // ----------------------------------------
   // Clocks, wires and model state
   // ----------------------------------------
   localparam int         PROG = 1000;
   localparam logic [3:0] DT   = eeprom_slave_pkg::DEV_TYPE;
   logic        clk       = 1'b0;
   logic        lclk      = 1'b0;
   logic        rst_n     = 1'b0;
   logic [2:0]  sel       = 3'h0;
   logic        wp        = 1'b0;
   logic        prot_set  = 1'b0;
   logic [6:0]  prot_page = 7'h00;
   logic        scl, m_oe, sda_o, sda_oe, standby, busy;
   logic [31:0] seed      = 32'h00003f48;
   logic [10:0] la;
   int          nb;
   logic [7:0]  mem [2048];
   bit          known [2048];
   bit          prot [128];
   int          fail_count = 0;
   int          n_compared = 0;
   // Pull-up: the wire is low only while some party pulls
   wire         sda = !m_oe && (sda_oe ? sda_o : 1'b1);

   always #2.5 clk = ~clk;
   // Link timebase offset so its edges never meet the system clock
   initial begin
      #1.3;
      forever #15 lclk = ~lclk;
   end

   eeprom_slave #(.PROG_CYCLES(PROG)) dut (
      .CLK_SYS(clk), .RST_N(rst_n), .SCL(scl), .SDA_I(sda), .SDA_O(sda_o), .SDA_OE(sda_oe),
      .UNUSED_SELECT_INPUT_0(sel[0]), .UNUSED_SELECT_INPUT_1(sel[1]),
      .UNUSED_SELECT_INPUT_2(sel[2]), .WRITE_PROTECT(wp), .PROT_SET(prot_set),
      .PROT_PAGE(prot_page), .STANDBY(standby), .PROG_BUSY(busy));
   i2c_bus_master m (.lclk(lclk), .sda(sda), .scl(scl), .sda_oe(m_oe));

   function automatic logic [31:0] rnd();
      seed = seed ^ (seed << 13);
      seed = seed ^ (seed >> 17);
      seed = seed ^ (seed << 5);
      return seed;
   endfunction
   // upper half under the pin, pages under their bits
   function automatic logic blocked(input logic [10:0] a);
      return (wp && a[10]) || prot[a[10:4]];
   endfunction
   // Write offsets wrap inside the 16 byte page
   function automatic logic [10:0] slot(input logic [10:0] a, input int i);
      return {a[10:4], a[3:0] + i[3:0]};
   endfunction

   task automatic chk8(input logic [7:0] e, input logic [7:0] g);
      n_compared++;
      if (g !== e) begin
         fail_count++;
         $display("CHECK FAILED t=%0t exp=%h got=%h", $time, e, g);
      end
   endtask
   task automatic chk1(input logic e, input logic g);
      chk8({7'h00, e}, {7'h00, g});
   endtask
   task automatic send(input logic [7:0] tx, input logic e_nak);
      logic [7:0] rx;
      logic       ack;
      m.byte_io(tx, 1'b1, rx, ack);
      chk1(e_nak, ack);
   endtask
   // Bounded wait for the program flag to reach a level
   task automatic wait_busy(input logic lvl, input int lim);
      for (int k = 0; k < lim && busy !== lvl; k++) begin
         @(posedge clk);
      end
   endtask

   task automatic do_write(input logic [10:0] a, input int n);
      logic [7:0] d;
      logic       any;
      any = 1'b0;
      @(posedge clk);
      sel <= 3'(rnd());
      m.start_c();
      send({DT, a[10:8], 1'b0}, 1'b0);
      send(a[7:0], 1'b0);
      for (int i = 0; i < n; i++) begin
         d = 8'(rnd());
         send(d, 1'b0);
         if (!blocked(slot(a, i))) begin
            mem[slot(a, i)] = d;
            known[slot(a, i)] = 1'b1;
            any = 1'b1;
         end
      end
      m.stop_c();
      if (any) begin
         wait_busy(1'b1, 20);
         chk1(1'b1, busy);
         chk1(1'b0, standby);
         m.start_c();
         send({DT, 4'h1}, 1'b1);
         m.stop_c();
      end
      wait_busy(1'b0, PROG + 50);
      @(posedge clk);
      chk1(1'b0, busy);
      chk1(1'b1, standby);
   endtask

   task automatic do_read(input logic [10:0] a, input int n);
      logic [7:0]  rx;
      logic        ack;
      logic [10:0] p;
      @(posedge clk);
      m.start_c();
      send({DT, a[10:8], 1'b0}, 1'b0);
      send(a[7:0], 1'b0);
      m.start_c();
      send({DT, 3'(rnd()), 1'b1}, 1'b0);
      for (int i = 0; i < n; i++) begin
         p = a + 11'(i);
         m.byte_io(8'hff, i == n - 1, rx, ack);
         if (known[p]) begin
            chk8(mem[p], rx);
         end
      end
      m.stop_c();
      wait_busy(1'b1, 20);
      chk1(1'b0, busy);
      chk1(1'b1, standby);
   endtask

   task automatic end_of_test();
      $display("compared %0d mismatches %0d", n_compared, fail_count);
      if (fail_count == 0 && n_compared > 0) begin
         $display("DONE - PASS");
      end else begin
         $display("DONE - FAIL");
      end
      $finish;
   endtask

   // ----------------------------------------
   // Main sequence
   // ----------------------------------------
   initial begin
      repeat (4) @(posedge clk);
      chk1(1'b1, standby);
      rst_n <= 1'b1;
      repeat (8) @(posedge clk);
      @(posedge clk);
      m.start_c();
      send({DT ^ 4'h1, 4'h0}, 1'b1);
      send(8'h00, 1'b1);
      m.stop_c();
      // Page wrap: offsets 14, 15 then 0
      la = {1'b0, 6'(rnd()), 4'he};
      do_write(la, 3);
      do_read(la, 2);
      do_read({la[10:4], 4'h0}, 1);
      // Offsets kept below 8 so a read never runs onto never-written bytes
      for (int t = 0; t < 3; t++) begin
         la = 11'(rnd()) & 11'h7f7;
         nb = 1 + int'(rnd() % 4);
         do_write(la, nb);
         do_read(la, nb);
      end
      la = {1'b1, 10'(rnd())};
      do_write(la, 1);
      wp <= 1'b1;
      repeat (4) @(posedge clk);
      do_write(la, 1);
      do_read(la, 1);
      do_write(la ^ 11'h400, 1);
      do_read(la ^ 11'h400, 1);
      wp <= 1'b0;
      la = {1'b0, 10'(rnd()) & 10'h3f7};
      do_write(la, 2);
      prot_set <= 1'b1;
      prot_page <= la[10:4];
      @(posedge clk);
      prot_set <= 1'b0;
      prot[la[10:4]] = 1'b1;
      do_write(la, 2);
      do_read(la, 2);
      end_of_test();
   end

   // Cuts a hang short, well past the expected run length
   initial begin
      repeat (90000) @(posedge clk);
      fail_count++;
      end_of_test();
   end
endmodule // testbench
